// ---- core/srp_fifo.sv ----
// Dual-clock FIFO with gray-coded pointers and valid/ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module srp_fifo
  import srp_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = SRP_FIFO_DEPTH
) (
  input wire logic wr_clk,
  input wire logic wr_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic rd_clk,
  input wire logic rd_rst,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH) + 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wbin, next_wbin, rbin, next_rbin;
  logic [PW-1:0] wgray, rgray;
  logic [PW-1:0] wg_s1, wg_s2, rg_s1, rg_s2;
  logic push, pop;

  function automatic logic [PW-1:0] to_gray(input logic [PW-1:0] b);
    return b ^ (b >> 1);
  endfunction

  assign wgray = to_gray(wbin);
  assign rgray = to_gray(rbin);
  // Full when the write pointer is a lap ahead of the read pointer.
  assign in_ready = !wr_rst &&
    (wgray != {~rg_s2[PW-1:PW-2], rg_s2[PW-3:0]});
  assign out_valid = !rd_rst && (rgray != wg_s2);
  assign out_data = mem[rbin[PW-2:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    next_wbin = push ? wbin + 1'b1 : wbin;
    next_rbin = pop ? rbin + 1'b1 : rbin;
  end

  always_ff @(posedge wr_clk) begin
    if (push) begin
      mem[wbin[PW-2:0]] <= in_data;
    end
  end

  always_ff @(posedge wr_clk) begin
    if (wr_rst) begin
      wbin <= '0;
      rg_s1 <= '0;
      rg_s2 <= '0;
    end else begin
      wbin <= next_wbin;
      rg_s1 <= rgray;
      rg_s2 <= rg_s1;
    end
  end

  always_ff @(posedge rd_clk) begin
    if (rd_rst) begin
      rbin <= '0;
      wg_s1 <= '0;
      wg_s2 <= '0;
    end else begin
      rbin <= next_rbin;
      wg_s1 <= wgray;
      wg_s2 <= wg_s1;
    end
  end

endmodule
`default_nettype wire

// ---- core/srp_pkg.sv ----
// Shared constants, types and helpers for the SRAM read port front end.
package srp_pkg;

  // Largest data and index widths over all organisations, used to size the carrier structs.
  localparam int SRP_MAX_DATA_W = 36;
  localparam int SRP_MAX_ADDR_W = 21;

  // Default organisation of the device.
  localparam int SRP_DEF_DATA_W = 18;

  // Word index widths per organisation.
  localparam int SRP_ADDR_W_NARROW = 21;
  localparam int SRP_ADDR_W_MID = 20;
  localparam int SRP_ADDR_W_WIDE = 19;

  // Words returned by every read access.
  localparam int SRP_BURST_LEN = 2;

  // Depth of each clock crossing buffer.
  localparam int SRP_FIFO_DEPTH = 16;

  // Flip-flops in each reset and pointer synchroniser.
  localparam int SRP_SYNC_STAGES = 2;

  // Values after reset.
  localparam logic SRP_RST_OE_N = 1'b1;
  localparam logic SRP_RST_FLAG = 1'b0;
  localparam logic SRP_RST_MODE = 1'b0;

  typedef logic [SRP_MAX_ADDR_W-1:0] srp_addr_t;

  // Two words of one burst, first word in word0.
  typedef struct packed {
    logic [SRP_MAX_DATA_W-1:0] word0;
    logic [SRP_MAX_DATA_W-1:0] word1;
  } srp_burst_t;

  // Word index width that a data width needs.
  function automatic int srp_addr_width(input int data_w);
    if (data_w <= 9) begin
      return SRP_ADDR_W_NARROW;
    end else if (data_w <= 18) begin
      return SRP_ADDR_W_MID;
    end else begin
      return SRP_ADDR_W_WIDE;
    end
  endfunction

endpackage

// ---- core/srp_read_port.sv ----
// Read port and shared address front end of a DDR separate-I/O SRAM.
//
// Function
// R1: Read address on K rise, write on K-bar.
// R2: One shared address bus, alternate edges.
// R3: Index width 21, 20 or 19 bits.
// R4: Deselected port ignores the address inputs.
// R5: One output word per output clock edge.
// R6: Single clock mode launches on K edges.
// R7: Outputs tristate while read port deselected.
// R8: Output bus is 8, 9, 18 or 36 bits.
// R9: Low read select at K rise starts read.
// R10: Pending read finishes, then outputs release.
// R11: Each read returns exactly two words.
// R12: Low write select at K rise starts write.
`timescale 1ns/1ps
`default_nettype none
module srp_read_port
  import srp_pkg::*;
#(
  parameter int DATA_W = SRP_DEF_DATA_W,
  parameter int ADDR_W = srp_addr_width(DATA_W),
  parameter int FIFO_DEPTH = SRP_FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic single_clock_mode,
  input wire logic k_clk,
  input wire logic c_clk,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic read_port_select_n,
  input wire logic write_port_select_n,
  output logic [DATA_W-1:0] q,
  output logic q_oe_n,
  output logic [ADDR_W-1:0] write_addr,
  output logic write_addr_strobe,
  output logic read_overrun,
  input wire logic load_en,
  input wire logic [ADDR_W-1:0] load_addr,
  input wire logic [DATA_W-1:0] load_word0,
  input wire logic [DATA_W-1:0] load_word1
);

  typedef enum logic [2:0] {
    SRP_IDLE = 3'b001,
    SRP_FETCH = 3'b010,
    SRP_PUSH = 3'b100
  } srp_state_t;

  // Narrows a carrier word to the organisation's width.
  function automatic logic [DATA_W-1:0] to_word(
      input logic [SRP_MAX_DATA_W-1:0] w);
    return w[DATA_W-1:0];
  endfunction

  // Reset synchronisers for the K and output clock domains.
  logic k_rst_s1, k_rst;
  logic q_rst_s1, q_rst;
  logic next_k_rst_s1, next_k_rst;
  logic next_q_rst_s1, next_q_rst;
  logic ref_rst;

  assign ref_rst = !nrst;

  // Single clock mode strap, brought into the system domain.
  logic mode_s1, mode_s2, mode_sel;
  logic next_mode_s1, next_mode_s2, next_mode_sel;
  logic q_clk;

  always_comb begin
    next_mode_s1 = single_clock_mode;
    next_mode_s2 = mode_s1;
    next_mode_sel = mode_s2;
  end

  always_ff @(posedge ref_clk) begin
    if (ref_rst) begin
      mode_s1 <= SRP_RST_MODE;
      mode_s2 <= SRP_RST_MODE;
      mode_sel <= SRP_RST_MODE;
    end else begin
      mode_s1 <= next_mode_s1;
      mode_s2 <= next_mode_s2;
      mode_sel <= next_mode_sel;
    end
  end

  // The strap is static in use, so the selected clock does not glitch.
  assign q_clk = mode_sel ? k_clk : c_clk; // R6

  always_comb begin
    next_k_rst_s1 = ref_rst;
    next_k_rst = k_rst_s1;
  end

  always_ff @(posedge k_clk) begin
    k_rst_s1 <= next_k_rst_s1;
    k_rst <= next_k_rst;
  end

  always_comb begin
    next_q_rst_s1 = ref_rst;
    next_q_rst = q_rst_s1;
  end

  always_ff @(posedge q_clk) begin
    q_rst_s1 <= next_q_rst_s1;
    q_rst <= next_q_rst;
  end

  // Address capture on the link clock.
  logic a_in_valid, a_in_ready;
  srp_addr_t a_in_data;
  logic wsel_hit, next_wsel_hit;
  logic next_overrun;
  logic [ADDR_W-1:0] next_write_addr;
  logic next_write_strobe;

  // A low read select at K rise pushes the read index.
  assign a_in_valid = !read_port_select_n && !k_rst; // R9 R4
  assign a_in_data = srp_addr_t'(addr); // R1 R2

  always_comb begin
    next_wsel_hit = !write_port_select_n; // R12
    next_overrun = read_overrun;
    if (a_in_valid && !a_in_ready) begin
      next_overrun = 1'b1;
    end
  end

  always_ff @(posedge k_clk) begin
    if (k_rst) begin
      wsel_hit <= SRP_RST_FLAG;
      read_overrun <= SRP_RST_FLAG;
    end else begin
      wsel_hit <= next_wsel_hit;
      read_overrun <= next_overrun;
    end
  end

  // The write index follows on the K-bar rise of the same cycle.
  always_comb begin
    next_write_strobe = wsel_hit; // R12 R4
    next_write_addr = write_addr;
    if (wsel_hit) begin
      next_write_addr = addr; // R1 R2
    end
  end

  always_ff @(negedge k_clk) begin
    if (k_rst) begin
      write_addr <= '0;
      write_addr_strobe <= SRP_RST_FLAG;
    end else begin
      write_addr <= next_write_addr;
      write_addr_strobe <= next_write_strobe;
    end
  end

  // Read index crossing into the system domain.
  logic a_out_valid, a_out_ready;
  srp_addr_t a_out_data;

  srp_fifo #(
    .WIDTH(SRP_MAX_ADDR_W),
    .DEPTH(FIFO_DEPTH)
  ) u_addr_fifo (
    .wr_clk(k_clk),
    .wr_rst(k_rst),
    .in_valid(a_in_valid),
    .in_ready(a_in_ready),
    .in_data(a_in_data),
    .rd_clk(ref_clk),
    .rd_rst(ref_rst),
    .out_valid(a_out_valid),
    .out_ready(a_out_ready),
    .out_data(a_out_data)
  );

  // Memory core: two equal arrays, one per word of the burst.
  logic [DATA_W-1:0] array0 [2**ADDR_W]; // R3 R11
  logic [DATA_W-1:0] array1 [2**ADDR_W]; // R3 R11

  always_ff @(posedge ref_clk) begin
    if (load_en) begin
      array0[load_addr] <= load_word0;
      array1[load_addr] <= load_word1;
    end
  end

  srp_state_t state, next_state;
  logic [ADDR_W-1:0] fetch_addr, next_fetch_addr;
  srp_burst_t burst, next_burst;
  logic b_in_valid, b_in_ready;

  assign a_out_ready = (state == SRP_IDLE);
  assign b_in_valid = (state == SRP_PUSH);

  always_comb begin
    next_state = state;
    next_fetch_addr = fetch_addr;
    next_burst = burst;
    case (state)
      SRP_IDLE: begin
        if (a_out_valid) begin
          next_fetch_addr = a_out_data[ADDR_W-1:0];
          next_state = SRP_FETCH;
        end
      end
      SRP_FETCH: begin
        next_burst = '0;
        next_burst.word0[DATA_W-1:0] = array0[fetch_addr]; // R11
        next_burst.word1[DATA_W-1:0] = array1[fetch_addr]; // R11
        next_state = SRP_PUSH;
      end
      SRP_PUSH: begin
        // Output buffer full stalls the core and, in turn, the index FIFO.
        if (b_in_ready) begin
          next_state = SRP_IDLE;
        end
      end
      default: begin
        next_state = SRP_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (ref_rst) begin
      state <= SRP_IDLE;
      fetch_addr <= '0;
      burst <= '0;
    end else begin
      state <= next_state;
      fetch_addr <= next_fetch_addr;
      burst <= next_burst;
    end
  end

  // Burst crossing into the output clock domain.
  logic b_out_valid, b_out_ready;
  srp_burst_t b_out_data;

  srp_fifo #(
    .WIDTH($bits(srp_burst_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_burst_fifo (
    .wr_clk(ref_clk),
    .wr_rst(ref_rst),
    .in_valid(b_in_valid),
    .in_ready(b_in_ready),
    .in_data(burst),
    .rd_clk(q_clk),
    .rd_rst(q_rst),
    .out_valid(b_out_valid),
    .out_ready(b_out_ready),
    .out_data(b_out_data)
  );

  // Output stage: word0 on the rising edge, word1 on the falling edge.
  logic [DATA_W-1:0] q_rise, next_q_rise;
  logic [DATA_W-1:0] q_fall, next_q_fall;
  logic [DATA_W-1:0] hold1, next_hold1;
  logic next_q_oe_n;

  assign b_out_ready = !q_rst;

  always_comb begin
    next_q_rise = q_rise;
    next_hold1 = hold1;
    next_q_oe_n = SRP_RST_OE_N; // R7 R10
    if (b_out_valid) begin
      next_q_rise = to_word(b_out_data.word0); // R5 R11
      next_hold1 = to_word(b_out_data.word1); // R5 R11
      next_q_oe_n = 1'b0;
    end
  end

  always_ff @(posedge q_clk) begin
    if (q_rst) begin
      q_rise <= '0;
      hold1 <= '0;
      q_oe_n <= SRP_RST_OE_N;
    end else begin
      q_rise <= next_q_rise;
      hold1 <= next_hold1;
      q_oe_n <= next_q_oe_n;
    end
  end

  always_comb begin
    next_q_fall = hold1; // R5
  end

  always_ff @(negedge q_clk) begin
    if (q_rst) begin
      q_fall <= '0;
    end else begin
      q_fall <= next_q_fall;
    end
  end

  // Double data rate output multiplexer, one word per clock phase.
  assign q = q_clk ? q_rise : q_fall; // R5 R8

endmodule
`default_nettype wire

// ---- dv/srp_ctrl_model.sv ----
// Memory controller model: input and output clocks, index and selects.
`timescale 1ns/1ps
`default_nettype none
module srp_ctrl_model #(
  parameter int ADDR_W = 20
) (
  output var logic k_clk,
  output var logic c_clk,
  output var logic [ADDR_W-1:0] addr,
  output var logic read_port_select_n,
  output var logic write_port_select_n
);
  initial begin
    k_clk = 1'b0;
    addr = '0;
    read_port_select_n = 1'b1;
    write_port_select_n = 1'b1;
    c_clk = 1'b0;
    #1.7;
    forever #3 c_clk = ~c_clk;
  end
  always #3 k_clk = ~k_clk;
  // One access per input clock cycle; the write index holds to K-bar rise.
  task automatic access(input logic rd, input logic wr,
      input logic [ADDR_W-1:0] ra, input logic [ADDR_W-1:0] wa);
    @(negedge k_clk);
    #0.5;
    read_port_select_n = !rd;
    write_port_select_n = !wr;
    addr = ra;
    @(posedge k_clk);
    #0.5;
    addr = wa;
    read_port_select_n = 1'b1;
    write_port_select_n = 1'b1;
  endtask
endmodule
`default_nettype wire

// ---- dv/srp_read_port_asserts.sv ----
// Pin-level checks for the read port front end.
`timescale 1ns/1ps
`default_nettype none
module srp_read_port_asserts
  import srp_pkg::*;
#(
  parameter int ADDR_W = SRP_ADDR_W_MID
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic single_clock_mode,
  input wire logic k_clk,
  input wire logic c_clk,
  input wire logic read_port_select_n,
  input wire logic write_port_select_n,
  input wire logic q_oe_n,
  input wire logic [ADDR_W-1:0] write_addr,
  input wire logic write_addr_strobe,
  input wire logic read_overrun
);
  wire logic q_clk = single_clock_mode ? k_clk : c_clk;
  logic [6:0] idle;
  logic oe_fall;
  // Enable level seen at each falling edge of the output clock.
  always_ff @(negedge q_clk) begin
    oe_fall <= q_oe_n;
  end
  // Counts input clock cycles since the last read request.
  always_ff @(posedge k_clk) begin
    if (!nrst || !read_port_select_n) begin
      idle <= 7'h00;
    end else if (idle != 7'h7f) begin
      idle <= idle + 7'h01;
    end
  end
  sequence s_wsel;
    !write_port_select_n;
  endsequence
  sequence s_rst;
    !nrst [*8];
  endsequence
  property p_wstb;
    @(posedge k_clk) disable iff (!nrst) s_wsel |=> write_addr_strobe;
  endproperty
  a_wstb: assert property (p_wstb) else $error("no write strobe");
  property p_nostb;
    @(posedge k_clk) disable iff (!nrst)
      write_port_select_n |=> !write_addr_strobe;
  endproperty
  a_nostb: assert property (p_nostb) else $error("stray strobe");
  property p_wkeep;
    @(posedge k_clk) disable iff (!nrst)
      write_port_select_n |=> $stable(write_addr);
  endproperty
  a_wkeep: assert property (p_wkeep) else $error("index moved");
  property p_oehold;
    @(posedge q_clk) disable iff (!nrst) q_oe_n == oe_fall;
  endproperty
  a_oehold: assert property (p_oehold) else $error("enable moved");
  property p_idle;
    @(posedge q_clk) disable iff (!nrst) idle == 7'h7f |-> q_oe_n;
  endproperty
  a_idle: assert property (p_idle) else $error("q still driven");
  property p_rd;
    @(posedge k_clk) disable iff (!nrst)
      !read_port_select_n |-> ##[1:40] !q_oe_n;
  endproperty
  a_rd: assert property (p_rd) else $error("read not answered");
  property p_ovr;
    @(posedge k_clk) disable iff (!nrst) $rose(read_overrun) |->
      !$past(read_port_select_n) || !$past(read_port_select_n, 2);
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun no cause");
  property p_rst;
    @(posedge ref_clk) s_rst |->
      q_oe_n && !write_addr_strobe && !read_overrun;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
endmodule
bind srp_read_port srp_read_port_asserts #(.ADDR_W(ADDR_W)) u_chk (
  .ref_clk, .nrst, .single_clock_mode, .k_clk, .c_clk, .read_port_select_n,
  .write_port_select_n, .q_oe_n, .write_addr, .write_addr_strobe,
  .read_overrun
);
`default_nettype wire

// ---- dv/srp_read_port_test.sv ----
// Self-checking bench for the SRAM read port front end.
`timescale 1ns/1ps
`default_nettype none
module srp_read_port_test
  import srp_pkg::*;
;
  localparam int AW = SRP_ADDR_W_MID;
  localparam int DW = SRP_DEF_DATA_W;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic single_clock_mode = 1'b0;
  logic load_en = 1'b0;
  logic [AW-1:0] load_addr = 20'h00000;
  logic [DW-1:0] load_word0 = 18'h00000;
  logic [DW-1:0] load_word1 = 18'h00000;
  logic k_clk, c_clk, read_port_select_n, write_port_select_n;
  logic [AW-1:0] addr, write_addr, ra, wa, wexp;
  logic [DW-1:0] q;
  logic q_oe_n, write_addr_strobe, read_overrun, rd, wr;
  srp_burst_t mem [logic [AW-1:0]];
  srp_burst_t rq [$];
  srp_burst_t cur;
  logic [AW-1:0] al [$];
  logic [AW-1:0] wq [$];
  int fails = 0;
  int samples_checked = 0;
  wire logic q_clk = single_clock_mode ? k_clk : c_clk;

  srp_ctrl_model #(.ADDR_W(AW)) u_ctrl (.k_clk, .c_clk, .addr,
    .read_port_select_n, .write_port_select_n);
  srp_read_port #(.DATA_W(DW)) u_dut (.ref_clk, .nrst, .single_clock_mode,
    .k_clk, .c_clk, .addr, .read_port_select_n, .write_port_select_n, .q,
    .q_oe_n, .write_addr, .write_addr_strobe, .read_overrun, .load_en,
    .load_addr, .load_word0, .load_word1);

  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    if (fails == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic load(input logic [AW-1:0] a);
    @(posedge ref_clk);
    #1;
    load_en = 1'b1;
    load_addr = a;
    load_word0 = DW'($urandom);
    load_word1 = DW'($urandom);
    mem[a] = '{word0: 36'(load_word0), word1: 36'(load_word1)};
    @(posedge ref_clk);
    #1;
    load_en = 1'b0;
  endtask

  // Waits until all bursts are out and the outputs have stayed released.
  task automatic drain();
    int t = 0;
    int h = 0;
    while (h < 80 && t < 3000) begin
      @(posedge ref_clk);
      t++;
      h = (q_oe_n === 1'b1 && rq.size() == 0) ? h + 1 : 0;
    end
    if (h < 80) begin
      fails++;
      end_of_test();
    end
  endtask

  always #5 ref_clk = ~ref_clk;

  always @(posedge q_clk) begin
    #1;
    if (nrst && q_oe_n === 1'b0) begin
      cur = rq.size() > 0 ? rq.pop_front() : mem[20'hfffff];
      check(36'(q), cur.word0);
      @(negedge q_clk);
      #1;
      check(36'(q), cur.word1);
    end
  end

  always @(negedge k_clk) begin
    #1;
    if (nrst && write_addr_strobe === 1'b1) begin
      wexp = wq.size() > 0 ? wq.pop_front() : ~write_addr;
      check(36'(write_addr), 36'(wexp));
    end
  end

  initial begin
    void'($urandom(74));
    for (int p = 0; p < 2; p++) begin
      #1;
      nrst = 1'b0;
      single_clock_mode = p[0];
      repeat (16) @(posedge ref_clk);
      #1;
      nrst = 1'b1;
      check(36'(read_overrun), 36'h0);
      al = {20'h00000, 20'hfffff};
      repeat (6) al.push_back(AW'($urandom));
      foreach (al[i]) load(al[i]);
      repeat (24) begin
        rd = 1'($urandom_range(1));
        wr = 1'($urandom_range(1));
        ra = al[$urandom_range(al.size() - 1)];
        wa = AW'($urandom);
        if (rd) rq.push_back(mem[ra]);
        if (wr) wq.push_back(wa);
        u_ctrl.access(rd, wr, ra, wa);
      end
      drain();
      repeat (80) u_ctrl.access(1'b1, 1'b0, 20'hfffff, 20'h00000);
      drain();
      check(36'(read_overrun), 36'h1);
      check(36'(q_oe_n), 36'h1);
    end
    end_of_test();
  end
endmodule
`default_nettype wire
